// ===== lbf_focus_framer.v
// Purpose: Receive four-byte focus and status packets, latch focus motors, send status reply
// Assumes: Byte UART on sys_clk supplies rx bytes and accepts tx bytes by valid/ready
// Notes:   Only four-byte packets are decoded; longer commands fail the check and drop
`include "lbf_defs.vh"

// Contract
// (RQ1) Valid 0x35 packet starts head one focus motor, latched until stopped.
// (RQ2) Valid 0x36 packet stops head one focus motor.
// (RQ3) Valid 0x37 packet starts second head focus motor when fitted, latched.
// (RQ4) Valid 0x38 packet stops second head focus motor when fitted.
// (RQ5) Packets are four bytes: sync, address, command, check.
// (RQ6) Check byte is low 7 bits of sum of all preceding bytes.
// (RQ7) Last byte of every packet is the check value.
// (RQ8) Packets start with 0xFF; remaining bytes follow without gaps.
// (RQ9) Packets taking longer than 30 ms from sync to check are discarded.
// (RQ10) Controller sends at most 10 packets per second; idle may be unbounded.
// (RQ11) After valid status request wait 2 to 30 ms, then send 13 bytes.
// (RQ12) After last reply byte leaves, release line and return to receive.
// (RQ13) Status request code 0x34, four-byte packet, triggers the reply.
// (RQ14) Reply second byte is lamp address with top bit set.
// (RQ15) Reply order: sync, address, pan, tilt, flags, focus, faults, version, type, check.
// (RQ16) Packets with bad check byte or foreign address are ignored.
// (RQ17) Controller leaves the line free until the reply completes.
module lbf_focus_framer #(
   parameter PKT_TMO_CYC   = `LBF_PKT_TMO_MS * `LBF_CLK_KHZ,
   parameter REPLY_DLY_CYC = `LBF_REPLY_DLY_MS * `LBF_CLK_KHZ,
   parameter TMR_W         = 20
) (
   input  wire        sys_clk,
   input  wire        nrst,
   input  wire [7:0]  rx_data,
   input  wire        rx_valid,
   input  wire [7:0]  own_addr,
   input  wire        head2_fitted,
   input  wire [15:0] pan_pos,
   input  wire [15:0] tilt_pos,
   input  wire [7:0]  lamp_flags,
   input  wire [7:0]  focus_pos,
   input  wire [7:0]  fault1,
   input  wire [7:0]  fault2,
   input  wire [7:0]  sw_version,
   input  wire [7:0]  lamp_type,
   input  wire        tx_ready,
   input  wire        tx_idle,
   output reg         focus1_run_q,
   output reg         focus2_run_q,
   output reg  [7:0]  tx_data_q,
   output reg         tx_valid_q,
   output reg         line_drive_q,
   output reg         pkt_drop_q
);

   localparam [1:0] S_RX    = 2'd0;
   localparam [1:0] S_WAIT  = 2'd1;
   localparam [1:0] S_TX    = 2'd2;
   localparam [1:0] S_DRAIN = 2'd3;

   localparam [TMR_W-1:0] TMO_LIM  = PKT_TMO_CYC[TMR_W-1:0];
   localparam [TMR_W-1:0] DLY_LIM  = REPLY_DLY_CYC[TMR_W-1:0];
   localparam [TMR_W-1:0] GRD_LIM  = `LBF_DRAIN_GUARD;
   localparam [TMR_W-1:0] TMR_STEP = {{(TMR_W-1){1'b0}}, 1'b1};
   localparam [TMR_W-1:0] TMR_CLR  = {TMR_W{1'b0}};

   // Receive framing
   reg             in_pkt_q;
   reg [1:0]       idx_q;
   reg [7:0]       sum_q;
   reg [7:0]       addr_q;
   reg [7:0]       cmd_q;
   reg [TMR_W-1:0] pkt_tmr_q;

   // Reply sequencing
   reg [1:0]       state_q;
   reg [1:0]       state_d;
   reg [TMR_W-1:0] dly_tmr_q;
   reg [3:0]       rep_idx_q;
   reg [7:0]       rep_sum_q;
   reg [7:0]       rep_byte;
   reg [3:0]       rep_sel;

   wire            rx_hunt;
   wire            rx_open;
   wire            sync_seen;
   wire            tmo_hit;
   wire            last_byte;
   wire            chk_ok;
   wire            addr_ok;
   wire            pkt_ok;
   wire            drop_now;
   wire            run1_cmd;
   wire            stop1_cmd;
   wire            run2_cmd;
   wire            stop2_cmd;
   wire            status_cmd;
   wire            wait_done;
   wire            tx_fire;
   wire            tx_done;
   wire            drain_done;

   // Bytes heard while waiting or sending are ignored
   assign rx_hunt    = (state_q == S_RX) && !in_pkt_q;
   assign rx_open    = (state_q == S_RX) && in_pkt_q;
   assign sync_seen  = rx_hunt && rx_valid && (rx_data == `LBF_SYNC); // RQ8
   assign tmo_hit    = rx_open && (pkt_tmr_q >= TMO_LIM); // RQ9
   // A check byte landing on the timeout edge is late, so timeout wins
   assign last_byte  = rx_open && !tmo_hit && rx_valid && (idx_q == `LBF_PKT_LAST); // RQ5 RQ7
   // Check byte has bit 7 clear, so the full byte must match
   assign chk_ok     = (rx_data == (sum_q & `LBF_CHK_MASK)); // RQ6
   assign addr_ok    = (addr_q == own_addr);
   assign pkt_ok     = last_byte && chk_ok && addr_ok; // RQ16
   assign drop_now   = tmo_hit || (last_byte && !pkt_ok); // RQ9 RQ16

   assign run1_cmd   = pkt_ok && (cmd_q == `LBF_CMD_FOCUS_RUN); // RQ1
   assign stop1_cmd  = pkt_ok && (cmd_q == `LBF_CMD_FOCUS_STP); // RQ2
   // Second head codes stay valid packets but do nothing when unfitted
   assign run2_cmd   = pkt_ok && head2_fitted && (cmd_q == `LBF_CMD_F2_RUN); // RQ3
   assign stop2_cmd  = pkt_ok && head2_fitted && (cmd_q == `LBF_CMD_F2_STP); // RQ4
   assign status_cmd = pkt_ok && (cmd_q == `LBF_CMD_STATUS); // RQ13

   assign wait_done  = (state_q == S_WAIT) && (dly_tmr_q >= DLY_LIM); // RQ11
   assign tx_fire    = tx_valid_q && tx_ready;
   assign tx_done    = (state_q == S_TX) && tx_fire && (rep_idx_q == `LBF_REPLY_LAST);
   // Guard lets the UART drop idle after taking the last byte
   assign drain_done = (state_q == S_DRAIN) && tx_idle && (dly_tmr_q >= GRD_LIM); // RQ12

   // Reply byte selected for loading next; status inputs are taken live
   always @* begin
      rep_sel = (state_q == S_WAIT) ? `LBF_RB_SYNC : rep_idx_q + 4'h1;
      case (rep_sel) // RQ15
         `LBF_RB_SYNC:    rep_byte = `LBF_SYNC;
         `LBF_RB_ADDR:    rep_byte = own_addr | `LBF_ADDR_TOP; // RQ14
         `LBF_RB_PAN_LO:  rep_byte = pan_pos[7:0];
         `LBF_RB_PAN_HI:  rep_byte = pan_pos[15:8];
         `LBF_RB_TILT_LO: rep_byte = tilt_pos[7:0];
         `LBF_RB_TILT_HI: rep_byte = tilt_pos[15:8];
         `LBF_RB_FLAGS:   rep_byte = lamp_flags;
         `LBF_RB_FOCUS:   rep_byte = focus_pos;
         `LBF_RB_FLT1:    rep_byte = fault1;
         `LBF_RB_FLT2:    rep_byte = fault2;
         `LBF_RB_VER:     rep_byte = sw_version;
         `LBF_RB_TYPE:    rep_byte = lamp_type;
         `LBF_REPLY_LAST: rep_byte = rep_sum_q & `LBF_CHK_MASK;
         default:         rep_byte = `LBF_SYNC;
      endcase
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         in_pkt_q <= 1'b0;
         idx_q    <= 2'd0;
         sum_q    <= 8'h00;
         addr_q   <= 8'h00;
         cmd_q    <= 8'h00;
      end else if (sync_seen) begin
         in_pkt_q <= 1'b1;
         idx_q    <= `LBF_POS_ADDR;
         sum_q    <= rx_data;
      end else if (tmo_hit || last_byte) begin
         // Idle hunt has no time limit; only a sync reopens a packet
         in_pkt_q <= 1'b0;
      end else if (rx_open && rx_valid) begin
         // A sync value inside a packet is plain data
         idx_q <= idx_q + 2'd1;
         sum_q <= sum_q + rx_data; // RQ6
         if (idx_q == `LBF_POS_ADDR) begin
            addr_q <= rx_data;
         end
         if (idx_q == `LBF_POS_CMD) begin
            cmd_q <= rx_data;
         end
      end
   end

   // Packet age counts only while a packet is open
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pkt_tmr_q <= TMR_CLR;
      end else if (rx_open && !tmo_hit) begin
         pkt_tmr_q <= pkt_tmr_q + TMR_STEP; // RQ9
      end else begin
         pkt_tmr_q <= TMR_CLR;
      end
   end

   // One-cycle pulse per discarded packet
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pkt_drop_q <= 1'b0;
      end else begin
         pkt_drop_q <= drop_now;
      end
   end

   // Latched until the opposite command; slow senders need no refresh
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         focus1_run_q <= 1'b0;
      end else if (run1_cmd) begin
         focus1_run_q <= 1'b1; // RQ1
      end else if (stop1_cmd) begin
         focus1_run_q <= 1'b0; // RQ2
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         focus2_run_q <= 1'b0;
      end else if (run2_cmd) begin
         focus2_run_q <= 1'b1; // RQ3
      end else if (stop2_cmd) begin
         focus2_run_q <= 1'b0; // RQ4
      end
   end

   always @* begin
      state_d = state_q;
      case (state_q)
         S_RX: begin
            if (status_cmd) begin
               state_d = S_WAIT; // RQ13
            end
         end
         S_WAIT: begin
            if (wait_done) begin
               state_d = S_TX; // RQ11
            end
         end
         S_TX: begin
            if (tx_done) begin
               state_d = S_DRAIN;
            end
         end
         S_DRAIN: begin
            if (drain_done) begin
               state_d = S_RX; // RQ12
            end
         end
         default: begin
            state_d = S_RX;
         end
      endcase
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_RX;
      end else begin
         state_q <= state_d;
      end
   end

   // Delay and drain share one timer; each starts from zero
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dly_tmr_q <= TMR_CLR;
      end else if ((state_q == S_WAIT) || (state_q == S_DRAIN)) begin
         if (state_d == state_q) begin
            dly_tmr_q <= dly_tmr_q + TMR_STEP; // RQ11
         end else begin
            dly_tmr_q <= TMR_CLR;
         end
      end else begin
         dly_tmr_q <= TMR_CLR;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_data_q  <= 8'h00;
         tx_valid_q <= 1'b0;
         rep_idx_q  <= 4'h0;
         rep_sum_q  <= 8'h00;
      end else if (wait_done) begin
         tx_valid_q <= 1'b1; // RQ11
         tx_data_q  <= rep_byte;
         rep_idx_q  <= `LBF_RB_SYNC;
         rep_sum_q  <= rep_byte;
      end else if (tx_done) begin
         // Last handshake drops valid; drain then waits for idle
         tx_valid_q <= 1'b0;
      end else if ((state_q == S_TX) && tx_fire) begin
         // Valid stays up across bytes so the reply leaves back to back
         rep_idx_q <= rep_sel;
         tx_data_q <= rep_byte; // RQ11
         rep_sum_q <= rep_sum_q + rep_byte;
      end
   end

   // Driver enable brackets the whole reply
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         line_drive_q <= 1'b0;
      end else if (wait_done) begin
         line_drive_q <= 1'b1; // RQ11
      end else if (drain_done) begin
         line_drive_q <= 1'b0; // RQ12
      end
   end

endmodule // lbf_focus_framer

// ===== lbf_defs.vh
// Purpose: Constants for the lamp serial bus focus command framer
// Assumes: 20 MHz system clock
// Notes:   Times are in milliseconds except the drain guard, given in cycles; counts derived in the module
`ifndef LBF_DEFS_VH
`define LBF_DEFS_VH
`define LBF_SYNC          8'hff
`define LBF_CMD_STATUS    8'h34
`define LBF_CMD_FOCUS_RUN 8'h35
`define LBF_CMD_FOCUS_STP 8'h36
`define LBF_CMD_F2_RUN    8'h37
`define LBF_CMD_F2_STP    8'h38
`define LBF_ADDR_TOP      8'h80
`define LBF_CHK_MASK      8'h7f
`define LBF_POS_ADDR      2'd1
`define LBF_POS_CMD       2'd2
`define LBF_PKT_LAST      2'd3
`define LBF_RB_SYNC       4'h0
`define LBF_RB_ADDR       4'h1
`define LBF_RB_PAN_LO     4'h2
`define LBF_RB_PAN_HI     4'h3
`define LBF_RB_TILT_LO    4'h4
`define LBF_RB_TILT_HI    4'h5
`define LBF_RB_FLAGS      4'h6
`define LBF_RB_FOCUS      4'h7
`define LBF_RB_FLT1       4'h8
`define LBF_RB_FLT2       4'h9
`define LBF_RB_VER        4'ha
`define LBF_RB_TYPE       4'hb
`define LBF_REPLY_LAST    4'hc
`define LBF_CLK_KHZ       20000
`define LBF_PKT_TMO_MS    30
`define LBF_REPLY_DLY_MS  10
`define LBF_DRAIN_GUARD   20'h00002
`endif

// ===== lbf_focus_framer_properties.sv
// Purpose: Port assertions for the focus framer
// Assumes: One clock, reset active low
// Notes:   Bound to every framer instance
module lbf_focus_framer_props #(parameter PKT_TMO_CYC = 1, REPLY_DLY_CYC = 1, TMR_W = 20) (
   input wire logic       sys_clk, nrst, rx_valid, head2_fitted, tx_ready, tx_idle,
   input wire logic       focus1_run_q, focus2_run_q, tx_valid_q, line_drive_q, pkt_drop_q,
   input wire logic [7:0] tx_data_q
);
   timeunit 1ns; timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_valid_in_drive: assert property (tx_valid_q |-> line_drive_q)
      else $error("tx valid outside drive");
   a_drive_opens_sync: assert property ($rose(line_drive_q) |-> $rose(tx_valid_q) && tx_data_q == 8'hff)
      else $error("reply not opened by sync");
   a_tx_byte_hold: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
      else $error("reply byte lost");
   a_release_on_idle: assert property ($fell(line_drive_q) |-> $past(tx_idle) && !tx_valid_q)
      else $error("line released early");
   a_drop_one_cycle: assert property (pkt_drop_q |=> !pkt_drop_q)
      else $error("drop pulse too long");
   a_drop_keeps_run: assert property (pkt_drop_q |-> $stable(focus1_run_q) && $stable(focus2_run_q))
      else $error("dropped packet moved focus");
   a_run1_cause: assert property ($changed(focus1_run_q) |-> $past(rx_valid) && !line_drive_q)
      else $error("focus one changed without packet");
   a_run2_gated: assert property ($changed(focus2_run_q) |-> $past(head2_fitted) && $past(rx_valid))
      else $error("focus two changed unfitted");
endmodule // lbf_focus_framer_props
bind lbf_focus_framer lbf_focus_framer_props #(.PKT_TMO_CYC(PKT_TMO_CYC), .REPLY_DLY_CYC(REPLY_DLY_CYC),
   .TMR_W(TMR_W)) u_props (.sys_clk(sys_clk), .nrst(nrst), .rx_valid(rx_valid), .head2_fitted(head2_fitted),
   .tx_ready(tx_ready), .tx_idle(tx_idle), .focus1_run_q(focus1_run_q), .focus2_run_q(focus2_run_q),
   .tx_valid_q(tx_valid_q), .line_drive_q(line_drive_q), .pkt_drop_q(pkt_drop_q), .tx_data_q(tx_data_q));

// ===== lbf_uart_model.sv
// Purpose: Byte transmitter on the far side of the reply path
// Assumes: Stall input chosen by the bench
// Notes:   Shifter busy five cycles per byte
module lbf_uart_model (
   input wire logic  sys_clk, nrst, tx_valid, stall,
   output logic      tx_ready, tx_idle
);
   timeunit 1ns; timeprecision 100ps;
   logic [2:0] cnt_q;
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_ready <= 1'b0;
         tx_idle  <= 1'b1;
         cnt_q    <= 3'h0;
      end else begin
         tx_ready <= !stall;
         if (tx_valid && tx_ready) begin // Idle drops at once
            tx_idle <= 1'b0;
            cnt_q   <= 3'h4;
         end else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
         else tx_idle <= 1'b1;
      end
   end
endmodule // lbf_uart_model

// ===== tb.sv
// Purpose: Self-checking bench for the focus framer
// Assumes: Short timeout and reply delay parameters
// Notes:   Reference model kept in integers
module tb;
   timeunit 1ns; timeprecision 100ps;
   logic sys_clk = 0, nrst = 0, rx_valid = 0, head2_fitted = 1, stall = 0;
   logic [7:0] rx_data = 0, own_addr = 8'h93, fl = 0, fp = 0, f1 = 0, f2 = 0, ver = 0, typ = 0;
   logic [15:0] pan = 0, tilt = 0;
   wire tx_ready, tx_idle, run1, run2, tx_valid_q, line_drive_q, pkt_drop_q;
   wire [7:0] tx_data_q;
   int failures = 0, compares = 0, drops = 0, e1 = 0, e2 = 0, ed = 0, n, i, k;
   logic [7:0] q[$], e[13], s;
   lbf_focus_framer #(.PKT_TMO_CYC(200), .REPLY_DLY_CYC(50), .TMR_W(20)) uut (.sys_clk(sys_clk), .nrst(nrst),
      .rx_data(rx_data), .rx_valid(rx_valid), .own_addr(own_addr), .head2_fitted(head2_fitted), .pan_pos(pan),
      .tilt_pos(tilt), .lamp_flags(fl), .focus_pos(fp), .fault1(f1), .fault2(f2), .sw_version(ver),
      .lamp_type(typ), .tx_ready(tx_ready), .tx_idle(tx_idle), .focus1_run_q(run1), .focus2_run_q(run2),
      .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q), .line_drive_q(line_drive_q), .pkt_drop_q(pkt_drop_q));
   lbf_uart_model u_far (.sys_clk(sys_clk), .nrst(nrst), .tx_valid(tx_valid_q), .stall(stall),
      .tx_ready(tx_ready), .tx_idle(tx_idle));
   initial forever #25 sys_clk = ~sys_clk;
   always @(negedge sys_clk) drops += pkt_drop_q;
   task end_of_test;
      if (failures == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick(int c);
      repeat (c) begin
         @(posedge sys_clk);
         #2;
      end
   endtask
   task put(logic [7:0] b);
      rx_data = b;
      rx_valid = 1;
      tick(1);
   endtask
   task send(logic [7:0] a, c, bad, int gap);
      s = 8'hff + a + c;
      put(8'hff);
      put(a);
      put(c);
      if (gap > 0) begin
         rx_valid = 0;
         tick(gap);
      end
      put({1'b0, s[6:0]} ^ bad);
      rx_valid = 0;
      tick(1);
      if (bad != 0 || a != own_addr || gap > 0) ed++;
      else if (c == 8'h35 || c == 8'h36) e1 = (c == 8'h35);
      else if (head2_fitted && (c == 8'h37 || c == 8'h38)) e2 = (c == 8'h37);
      chk("focus1", run1, e1);
      chk("focus2", run2, e2);
      chk("drops", drops, ed);
   endtask
   task reply;
      {pan, tilt, fl, fp} = {$urandom, $urandom};
      {f1, f2, ver, typ} = $urandom;
      send(own_addr, 8'h34, 0, 0);
      n = 0;
      while (!line_drive_q && n < 200) begin
         tick(1);
         n++;
      end
      chk("delay_ok", n >= 48 && n <= 52, 1);
      e = '{8'hff, own_addr | 8'h80, pan[7:0], pan[15:8], tilt[7:0], tilt[15:8], fl, fp, f1, f2, ver, typ, 0};
      for (i = 0; i < 12; i++) e[12] += e[i];
      e[12][7] = 0;
      q.delete();
      for (n = 0; q.size() < 13 && n < 400; n++) begin
         @(negedge sys_clk);
         if (tx_valid_q && tx_ready) q.push_back(tx_data_q);
      end
      for (i = 0; i < 13; i++) chk("reply_byte", q[i], e[i]);
      for (n = 0; line_drive_q && n < 100; n++) tick(1);
      chk("released", {line_drive_q, tx_valid_q}, 0);
   endtask
   always @(posedge sys_clk) #2 stall = ($urandom % 3 == 0);
   initial begin
      void'($urandom(32'h202d5051));
      tick(20);
      nrst = 1;
      chk("reset_out", {run1, run2, tx_valid_q, line_drive_q, pkt_drop_q}, 0);
      foreach (e[i]) if (i < 4) send(own_addr, 8'h35 + (i % 2) * 2 + i / 2, 0, 0);
      head2_fitted = 0;
      send(own_addr, 8'h37, 0, 0);
      send(own_addr, 8'h35, 8'h01, 0);
      send(own_addr + 1, 8'h35, 0, 0);
      send(own_addr, 8'h35, 0, 250);
      for (k = 0; k < 40; k++) begin
         head2_fitted = $urandom;
         send(own_addr + ($urandom % 4 == 0), 8'h35 + $urandom % 4, ($urandom % 5 == 0), 0);
         tick($urandom % 3);
      end
      reply();
      reply();
      send(own_addr, 8'h36, 0, 0);
      end_of_test();
   end
   initial begin
      #(20000 * 50);
      failures++;
      end_of_test();
   end
endmodule // tb
